/* rtl/pml_logic_top.sv */
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pml_logic_top #(
   parameter pml_pkg::pml_arch_t ARCH_INIT = pml_pkg::ARCH_RESET,
   parameter logic [31:0] ROW_INIT = pml_pkg::ROW_ERASED
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire pml_pkg::pml_bus_req_t busReq,
   output var logic [31:0] rdata,
   input wire pml_pkg::pml_pins_in_t pinsIn,
   output var pml_pkg::pml_pins_out_t pinsOut
);
   import pml_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NUM_TERMS-1:0][ROW_W-1:0] andArray;
      pml_arch_t arch;
      logic secured;
      logic [COUNT_W-1:0] progCount;
      logic [DATA_W-1:0] rdata;
      pml_pins_in_t sync1;
      pml_pins_in_t sync2;
      logic clkPrev;
      pml_pins_out_t pinsOut;
   } pml_top_state_t;

   localparam pml_pins_in_t PINS_IN_RESET = '{dedIn: 8'h00, clkPin: 1'b0, oePinN: 1'b1,
                                              ioIn: 8'h00};

   pml_top_state_t st_q;
   pml_top_state_t st_d;
   logic [1:0] rstSync;
   logic rstN;
   logic [NUM_LINES-1:0] arrayLines;
   logic [NUM_TERMS-1:0] pt;
   logic [NUM_CELLS-1:0] cellOut;
   logic [NUM_CELLS-1:0] cellOe;
   logic [NUM_CELLS-1:0] cellFb;
   logic clkEn;
   logic isArray;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic pml_func_t cellFunc(input pml_mode_t mode, input logic sel,
                                          input int idx);
      pml_func_t f;
      f = FN_INPUT;
      case (mode)
         MODE_SMALL: begin
            // The two middle cells have no input option in this mode
            if (sel || idx == 3 || idx == 4) begin
               f = FN_OUTPUT;
            end
         end
         MODE_REG: begin
            f = sel ? FN_REGISTER : FN_IO;
         end
         MODE_MEDIUM: begin
            f = (idx == 0 || idx == NUM_CELLS - 1) ? FN_TRISTATE : FN_IO;
         end
         default: begin
            f = FN_INPUT;
         end
      endcase
      return f;
   endfunction

   // A term is true while every connected column (a line or its inverse) is high; a cleared cell
   // disconnects its line, so that line cannot disturb the term
   function automatic logic productTerm(input logic [ROW_W-1:0] row,
                                        input logic [NUM_LINES-1:0] lines);
      logic [ROW_W-1:0] cols;
      cols = '0;
      for (int j = 0; j < NUM_LINES; j++) begin
         cols[2*j] = lines[j];
         cols[2*j+1] = ~lines[j];
      end
      return &(~row | cols);
   endfunction

   function automatic pml_arch_t archFromWord(input logic [DATA_W-1:0] w);
      pml_arch_t a;
      // Mode 3 is kept as written; every cell then acts as a plain input
      a.mode = pml_mode_t'(w[ARCH_MODE_LSB +: 2]);
      a.sel = w[ARCH_SEL_LSB +: NUM_CELLS];
      a.pol = w[ARCH_POL_LSB +: NUM_CELLS];
      return a;
   endfunction

   function automatic logic [DATA_W-1:0] archWord(input pml_arch_t a);
      logic [DATA_W-1:0] w;
      w = '0;
      w[ARCH_MODE_LSB +: 2] = a.mode;
      w[ARCH_SEL_LSB +: NUM_CELLS] = a.sel;
      w[ARCH_POL_LSB +: NUM_CELLS] = a.pol;
      return w;
   endfunction

   function automatic logic [DATA_W-1:0] statusWord(input logic sec,
                                                    input logic [COUNT_W-1:0] cnt);
      logic [DATA_W-1:0] w;
      w = '0;
      w[STATUS_SECURE_BIT] = sec;
      w[STATUS_COUNT_LSB +: COUNT_W] = cnt;
      return w;
   endfunction

   function automatic logic [DATA_W-1:0] pinsWord(input pml_pins_out_t p);
      logic [DATA_W-1:0] w;
      w = '0;
      w[0 +: NUM_CELLS] = p.ioOut;
      w[PINS_OE_LSB +: NUM_CELLS] = p.ioOe;
      return w;
   endfunction

   // Saturate rather than wrap, so a heavily cycled part never reads as fresh
   function automatic logic [COUNT_W-1:0] satInc(input logic [COUNT_W-1:0] cnt);
      logic [COUNT_W-1:0] n;
      n = cnt;
      if (cnt != {COUNT_W{1'b1}}) begin
         n = COUNT_W'(cnt + 1'b1);
      end
      return n;
   endfunction

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end

   assign rstN = rstSync[1];

   // ----------------------------------------------------------------
   // Logic array
   // ----------------------------------------------------------------
   always_comb begin
      if (st_q.arch.mode == MODE_REG) begin
         arrayLines = {cellFb, st_q.sync2.dedIn};
      end else begin
         // Outer cells lose their feedback to the clock and enable pins
         arrayLines = {st_q.sync2.oePinN, cellFb[6:1], st_q.sync2.clkPin,
                       st_q.sync2.dedIn};
      end
   end

   for (genvar k = 0; k < NUM_TERMS; k++) begin : gTerm
      assign pt[k] = productTerm(st_q.andArray[k], arrayLines);
   end

   // Edge taken only from the second sync stage; clkPrev resets high, but sync2 resets low,
   // so a clock already high at release still gives one edge once it reaches sync2
   assign clkEn = (st_q.arch.mode == MODE_REG) && st_q.sync2.clkPin && !st_q.clkPrev;

   for (genvar i = 0; i < NUM_CELLS; i++) begin : gCell
      pml_macrocell uCell (
         .mclk(mclk),
         .rstN(rstN),
         .func(cellFunc(st_q.arch.mode, st_q.arch.sel[i], i)),
         .pol(st_q.arch.pol[i]),
         .pt(pt[TERMS_PER_CELL*i +: TERMS_PER_CELL]),
         .clkEn(clkEn),
         .oeN(st_q.sync2.oePinN),
         .pinIn(st_q.sync2.ioIn[i]),
         .pinOut(cellOut[i]),
         .pinOe(cellOe[i]),
         .feedback(cellFb[i])
      );
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   assign isArray = (busReq.addr <= ADDR_ARRAY_LAST);

   always_comb begin
      st_d = st_q;
      st_d.sync1 = pinsIn;
      st_d.sync2 = st_q.sync1;
      st_d.clkPrev = st_q.sync2.clkPin;
      // Pins are registered, trading one cycle of latency for clean outputs
      st_d.pinsOut.ioOut = cellOut;
      st_d.pinsOut.ioOe = cellOe;
      st_d.rdata = '0;
      if (busReq.wr) begin
         if (isArray) begin
            if (!st_q.secured) begin
               st_d.andArray[busReq.addr[ARRAY_INDEX_W-1:0]] = busReq.wdata;
            end
         end else begin
            case (busReq.addr)
               ADDR_ARCH: begin
                  if (!st_q.secured) begin
                     st_d.arch = archFromWord(busReq.wdata);
                  end
               end
               ADDR_SECURE: begin
                  if (busReq.wdata[SECURE_SET_BIT]) begin
                     st_d.secured = 1'b1;
                  end
               end
               ADDR_ERASE: begin
                  if (busReq.wdata == ERASE_KEY) begin
                     for (int k = 0; k < NUM_TERMS; k++) begin
                        st_d.andArray[k] = ROW_ERASED;
                     end
                     st_d.arch = ARCH_RESET;
                     st_d.secured = 1'b0;
                     st_d.progCount = satInc(st_q.progCount);
                  end
               end
               default: begin
               end
            endcase
         end
      end
      if (busReq.rd) begin
         if (isArray) begin
            if (!st_q.secured) begin
               st_d.rdata = st_q.andArray[busReq.addr[ARRAY_INDEX_W-1:0]];
            end
         end else begin
            case (busReq.addr)
               ADDR_ARCH: begin
                  if (!st_q.secured) begin
                     st_d.rdata = archWord(st_q.arch);
                  end
               end
               ADDR_STATUS: begin
                  st_d.rdata = statusWord(st_q.secured, st_q.progCount);
               end
               ADDR_PINS: begin
                  st_d.rdata = pinsWord(st_q.pinsOut);
               end
               default: begin
                  st_d.rdata = '0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         for (int k = 0; k < NUM_TERMS; k++) begin
            st_q.andArray[k] <= ROW_INIT;
         end
         st_q.arch <= ARCH_INIT;
         st_q.secured <= 1'b0;
         st_q.progCount <= COUNT_RESET;
         st_q.rdata <= '0;
         st_q.sync1 <= PINS_IN_RESET;
         st_q.sync2 <= PINS_IN_RESET;
         st_q.clkPrev <= 1'b1;
         st_q.pinsOut <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;
   assign pinsOut = st_q.pinsOut;

endmodule // pml_logic_top
`default_nettype wire

/* rtl/pml_pkg.sv */
`default_nettype none
package pml_pkg;

   // ----------------------------------------------------------------
   // Array geometry
   // ----------------------------------------------------------------
   localparam int NUM_CELLS = 8;
   localparam int TERMS_PER_CELL = 8;
   localparam int NUM_TERMS = 64;
   localparam int NUM_LINES = 16;
   localparam int ROW_W = 32;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int ARRAY_INDEX_W = 6;
   localparam int COUNT_W = 16;

   // ----------------------------------------------------------------
   // Register word addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_ARRAY_LAST = 8'h3f;
   localparam logic [7:0] ADDR_ARCH = 8'h40;
   localparam logic [7:0] ADDR_SECURE = 8'h41;
   localparam logic [7:0] ADDR_ERASE = 8'h42;
   localparam logic [7:0] ADDR_STATUS = 8'h43;
   localparam logic [7:0] ADDR_PINS = 8'h44;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ARCH_MODE_LSB = 0;
   localparam int ARCH_SEL_LSB = 8;
   localparam int ARCH_POL_LSB = 16;
   localparam int SECURE_SET_BIT = 0;
   localparam int STATUS_SECURE_BIT = 0;
   localparam int STATUS_COUNT_LSB = 16;
   localparam int PINS_OE_LSB = 8;
   localparam logic [31:0] ERASE_KEY = 32'h0000_00e5;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SMALL = 2'b00,
      MODE_REG = 2'b01,
      MODE_MEDIUM = 2'b10,
      MODE_UNUSED = 2'b11
   } pml_mode_t;

   typedef enum logic [2:0] {
      FN_INPUT = 3'b000,
      FN_OUTPUT = 3'b001,
      FN_REGISTER = 3'b010,
      FN_IO = 3'b011,
      FN_TRISTATE = 3'b100
   } pml_func_t;

   typedef struct packed {
      pml_mode_t mode;
      logic [7:0] sel;
      logic [7:0] pol;
   } pml_arch_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pml_bus_req_t;

   typedef struct packed {
      logic [7:0] dedIn;
      logic clkPin;
      logic oePinN;
      logic [7:0] ioIn;
   } pml_pins_in_t;

   typedef struct packed {
      logic [7:0] ioOut;
      logic [7:0] ioOe;
   } pml_pins_out_t;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] ROW_ERASED = 32'hffff_ffff;
   localparam pml_arch_t ARCH_RESET = '{mode: MODE_SMALL, sel: 8'h00, pol: 8'h00};
   localparam logic [15:0] COUNT_RESET = 16'h0000;

endpackage
`default_nettype wire

/* rtl/pml_macrocell.sv */
`timescale 1ns/1ps
`default_nettype none
module pml_macrocell (
   input wire logic mclk,
   input wire logic rstN,
   input wire pml_pkg::pml_func_t func,
   input wire logic pol,
   input wire logic [7:0] pt,
   input wire logic clkEn,
   input wire logic oeN,
   input wire logic pinIn,
   output logic pinOut,
   output logic pinOe,
   output logic feedback
);
   import pml_pkg::*;

   typedef struct packed {
      logic regQ;
   } pml_cell_state_t;

   pml_cell_state_t st_q;
   pml_cell_state_t st_d;
   logic sumAll;
   logic sumSeven;

   assign sumAll = |pt;
   assign sumSeven = |pt[7:1];

   always_comb begin
      st_d = st_q;
      pinOut = 1'b0;
      pinOe = 1'b0;
      feedback = pinIn;
      case (func)
         FN_OUTPUT: begin
            pinOut = sumAll ^ pol;
            pinOe = 1'b1;
         end
         FN_REGISTER: begin
            // Polarity acts ahead of the flop, so the pin never sees it directly
            if (clkEn) begin
               st_d.regQ = sumAll ^ pol;
            end
            pinOut = ~st_q.regQ;
            pinOe = ~oeN;
            feedback = st_q.regQ;
         end
         FN_IO, FN_TRISTATE: begin
            // First term of the group is spent on the driver enable
            pinOut = sumSeven ^ pol;
            pinOe = pt[0];
         end
         default: begin
            pinOe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         st_q <= '{regQ: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

endmodule // pml_macrocell
`default_nettype wire

/* sim/pml_logic_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pml_logic_assertions #(
   parameter pml_pkg::pml_arch_t ARCH_INIT = pml_pkg::ARCH_RESET
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire pml_pkg::pml_bus_req_t busReq,
   input wire logic [31:0] rdata,
   input wire pml_pkg::pml_pins_in_t pinsIn,
   input wire pml_pkg::pml_pins_out_t pinsOut
);
   import pml_pkg::*;
   // ----
   // Shadow of software state and clock pin history
   // ----
   pml_arch_t arch_q;
   logic secured_q;
   logic [15:0] count_q;
   logic clkPrev_q;
   logic [3:0] riseAgo_q;
   logic eraseHit;
   assign eraseHit = busReq.wr && busReq.addr == ADDR_ERASE && busReq.wdata == ERASE_KEY;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         arch_q <= ARCH_INIT;
         secured_q <= 1'b0;
         count_q <= 16'h0000;
         clkPrev_q <= 1'b1;
         riseAgo_q <= 4'hf;
      end else begin
         clkPrev_q <= pinsIn.clkPin;
         if (pinsIn.clkPin && !clkPrev_q) begin
            riseAgo_q <= 4'h0;
         end else if (riseAgo_q != 4'hf) begin
            riseAgo_q <= riseAgo_q + 4'h1;
         end
         if (eraseHit) begin
            arch_q <= ARCH_RESET;
            secured_q <= 1'b0;
            count_q <= count_q + {15'h0000, count_q != 16'hffff};
         end else if (busReq.wr && busReq.addr == ADDR_SECURE && busReq.wdata[0]) begin
            secured_q <= 1'b1;
         end else if (busReq.wr && busReq.addr == ADDR_ARCH && !secured_q) begin
            arch_q <= '{mode: pml_mode_t'(busReq.wdata[1:0]), sel: busReq.wdata[15:8],
                        pol: busReq.wdata[23:16]};
         end
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_erase; eraseHit; endsequence
   sequence s_row_read; busReq.rd && busReq.addr <= ADDR_ARRAY_LAST; endsequence
   sequence s_reg_steady;
      (arch_q.mode == MODE_REG && $stable(arch_q) && $stable(pinsIn.oePinN)) [*8];
   endsequence
   sequence s_quiet; (!busReq.wr && $stable(pinsIn)) [*8]; endsequence
   a_read_data_slot: assert property (rdata != '0 |-> $past(busReq.rd))
      else $error("read data outside its slot");
   a_reset_clears: assert property ($rose(rst_n) |-> pinsOut == '0 && rdata == '0)
      else $error("outputs not clear in reset");
   a_reg_out_high: assert property (
      $rose(rst_n) && ARCH_INIT.mode == MODE_REG
      |-> ##4 (pinsOut.ioOut & ARCH_INIT.sel) == ARCH_INIT.sel)
      else $error("registered pins not high after reset");
   a_status_word: assert property (
      busReq.rd && busReq.addr == ADDR_STATUS |=> rdata == {count_q, 15'h0000, secured_q})
      else $error("status word wrong");
   a_locked_reads: assert property (
      busReq.rd && busReq.addr <= ADDR_ARCH && secured_q |=> rdata == '0)
      else $error("locked array readable");
   a_erase_wipes: assert property (
      s_erase ##1 !busReq.wr ##1 s_row_read |=> rdata == ROW_ERASED)
      else $error("row survives erase");
   a_reg_oe_follows: assert property (
      s_reg_steady |-> (pinsOut.ioOe & arch_q.sel) == ({8{~pinsIn.oePinN}} & arch_q.sel))
      else $error("registered enable wrong");
   a_reg_needs_clock: assert property (
      arch_q.mode == MODE_REG && $past(arch_q, 4) == arch_q && $past(rst_n, 6)
      && ((pinsOut.ioOut ^ $past(pinsOut.ioOut)) & arch_q.sel) != '0
      |-> riseAgo_q inside {[3:5]})
      else $error("registered pin moved without clock");
   a_quiet_pins: assert property (s_quiet |=> $stable(pinsOut))
      else $error("pins moved without cause");
endmodule // pml_logic_assertions
bind pml_logic_top pml_logic_assertions #(.ARCH_INIT(ARCH_INIT)) chk (
   .mclk(mclk),
   .rst_n(rst_n),
   .busReq(busReq),
   .rdata(rdata),
   .pinsIn(pinsIn),
   .pinsOut(pinsOut)
);
`default_nettype wire

/* sim/pml_board.sv */
`timescale 1ns/1ps
`default_nettype none
module pml_board (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pulseReq,
   input wire logic [7:0] dedIn,
   input wire logic oePinN,
   input wire pml_pkg::pml_pins_out_t pinsOut,
   output var pml_pkg::pml_pins_in_t pinsIn
);
   import pml_pkg::*;
   logic [2:0] pulse_q;
   // Clock pin rests low and never moves during reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_q <= 3'h0;
      end else if (pulse_q != 3'h0) begin
         pulse_q <= pulse_q - 3'h1;
      end else if (pulseReq) begin
         pulse_q <= 3'h6;
      end
   end
   // Undriven macrocell pins fall to board pull-downs
   always_comb begin
      pinsIn.dedIn = dedIn;
      pinsIn.clkPin = pulse_q > 3'h3;
      pinsIn.oePinN = oePinN;
      pinsIn.ioIn = pinsOut.ioOut & pinsOut.ioOe;
   end
endmodule // pml_board
`default_nettype wire

/* sim/tb_pml_logic_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin \
   checked++; \
   if ((s) !== (e)) begin \
      errTotal++; \
      $display("BAD %s expected %h seen %h", nm, e, s); \
   end \
end
module tb_pml_logic_top;
   import pml_pkg::*;
   localparam pml_arch_t ARCH_START = '{mode: MODE_REG, sel: 8'hf0, pol: 8'h0f};
   logic mclk;
   logic rst_n;
   pml_bus_req_t busReq;
   logic [31:0] rdata;
   pml_pins_in_t pinsIn;
   pml_pins_out_t pinsOut;
   logic pulseReq;
   logic [7:0] dedIn;
   logic oePinN;
   int errTotal;
   int checked;
   pml_logic_top #(.ARCH_INIT(ARCH_START)) DUT (
      .mclk(mclk),
      .rst_n(rst_n),
      .busReq(busReq),
      .rdata(rdata),
      .pinsIn(pinsIn),
      .pinsOut(pinsOut)
   );
   pml_board board (
      .mclk(mclk),
      .rst_n(rst_n),
      .pulseReq(pulseReq),
      .dedIn(dedIn),
      .oePinN(oePinN),
      .pinsOut(pinsOut),
      .pinsIn(pinsIn)
   );
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ----
   // Bus and pin helpers
   // ----
   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      busReq.addr <= a;
      busReq.wdata <= d;
      busReq.wr <= 1'b1;
      @(posedge mclk);
      busReq.wr <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge mclk);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge mclk);
      busReq.rd <= 1'b0;
      #1;
      `CHK(nm, e, rdata)
   endtask
   // Pin paths are synchronised, so allow the full pipeline to drain
   task automatic settle;
      repeat (8) @(posedge mclk);
      #1;
   endtask
   task automatic completeRun;
      $display("Comparisons %0d mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      errTotal++;
      completeRun();
   end
   // ----
   // Main sequence
   // ----
   initial begin
      rst_n = 1'b0;
      busReq = '0;
      pulseReq = 1'b0;
      dedIn = 8'h00;
      oePinN = 1'b0;
      errTotal = 0;
      checked = 0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      settle();
      `CHK("ioOut", 8'hff, pinsOut.ioOut)
      `CHK("ioOe", 8'hf0, pinsOut.ioOe)
      wrReg(8'h00, 32'h0000_0000);
      settle();
      `CHK("ioOe", 8'hf1, pinsOut.ioOe)
      @(posedge mclk);
      oePinN <= 1'b1;
      settle();
      `CHK("ioOe", 8'h01, pinsOut.ioOe)
      @(posedge mclk);
      oePinN <= 1'b0;
      wrReg(ADDR_ARCH, 32'h00a0_f001);
      dedIn <= 8'h5a;
      settle();
      `CHK("ioOut", 8'hf0, pinsOut.ioOut)
      @(posedge mclk);
      pulseReq <= 1'b1;
      @(posedge mclk);
      pulseReq <= 1'b0;
      settle();
      `CHK("ioOut", 8'h50, pinsOut.ioOut)
      rdChk(ADDR_STATUS, 32'h0000_0000, "status");
      wrReg(8'h05, 32'h1234_5678);
      rdChk(8'h05, 32'h1234_5678, "row5");
      wrReg(ADDR_SECURE, 32'h0000_0001);
      rdChk(ADDR_STATUS, 32'h0000_0001, "status");
      wrReg(8'h05, 32'h0000_0000);
      rdChk(8'h05, 32'h0000_0000, "row5");
      rdChk(ADDR_ARCH, 32'h0000_0000, "arch");
      wrReg(ADDR_ERASE, 32'h0000_00e4);
      rdChk(ADDR_STATUS, 32'h0000_0001, "status");
      wrReg(ADDR_ERASE, ERASE_KEY);
      rdChk(8'h05, ROW_ERASED, "row5");
      rdChk(ADDR_STATUS, 32'h0001_0000, "status");
      rdChk(ADDR_ARCH, 32'h0000_0000, "arch");
      rdChk(8'h80, 32'h0000_0000, "unmapped");
      wrReg(8'h01, 32'h8002_0000);
      wrReg(ADDR_ARCH, 32'h0000_0500);
      settle();
      `CHK("ioOe", 8'h1d, pinsOut.ioOe)
      `CHK("ioOut", 8'h01, pinsOut.ioOut & 8'h1d)
      @(posedge mclk);
      oePinN <= 1'b1;
      settle();
      `CHK("ioOut", 8'h00, pinsOut.ioOut & 8'h1d)
      wrReg(ADDR_ARCH, 32'h00ff_5a02);
      wrReg(8'h38, 32'h0000_0000);
      wrReg(8'h08, 32'h0000_0000);
      settle();
      `CHK("ioOe", 8'h82, pinsOut.ioOe)
      `CHK("ioOut", 8'h82, pinsOut.ioOut & 8'h82)
      rdChk(ADDR_PINS, 32'h0000_82ff, "pins");
      wrReg(ADDR_ARCH, 32'h0000_0003);
      settle();
      `CHK("ioOe", 8'h00, pinsOut.ioOe)
      wrReg(ADDR_ERASE, ERASE_KEY);
      rdChk(ADDR_STATUS, 32'h0002_0000, "status");
      completeRun();
   end
endmodule // tb_pml_logic_top
`default_nettype wire
